// ==== hdl/ppl_pkg.sv ====
// ppl_pkg: constants for the per-port preload map loader
// assumes a six-port switch with byte-offset configuration space per port
package ppl_pkg;

  // ---------------------------------------------------------------
  // preload word addresses
  // ---------------------------------------------------------------
  localparam logic [7:0]  PRELOAD_BASE   = 8'h80;   // word address of port 0
  localparam logic [7:0]  PRELOAD_STEP   = 8'h02;   // address step per port
  localparam logic [7:0]  PRELOAD_LAST   = 8'h8A;   // word address of port 5
  localparam int          NUM_PORTS      = 6;

  // ---------------------------------------------------------------
  // configuration offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFF_PM_CTRL    = 12'h074; // power-management control
  localparam logic [11:0] OFF_VGA_CTRL   = 12'h070; // vga decode enable
  localparam logic [11:0] OFF_VEND_CTRL5 = 12'h088; // vendor_control_reg_five

  // ---------------------------------------------------------------
  // preload word fields and target positions
  // ---------------------------------------------------------------
  localparam int RXPOL_SRC   = 6;   // disable rx polarity capability
  localparam int RXPOL_DST   = 14;
  localparam int PMGRP_SRC   = 0;   // six-bit group low end (d3, l1 delay, l0s)
  localparam int PMGRP_DST   = 8;
  localparam int PMGRP_W     = 6;
  localparam int VGA_SRC     = 7;   // vga decode enable
  localparam int VGA_DST     = 31;
  localparam int VEND_SRC    = 8;   // byte moved into bits 31:24
  localparam int VEND_DST    = 24;

  // write masks for each configuration write
  localparam logic [31:0] MASK_PM_CTRL   = 32'h0000_7F00;
  localparam logic [31:0] MASK_VGA_CTRL  = 32'h8000_0000;
  localparam logic [31:0] MASK_VEND_CTRL = 32'hFF00_0000;

  // loader states
  typedef enum logic [1:0] {PPL_IDLE, PPL_FETCH, PPL_WR_VGA, PPL_WR_VEND} ppl_state_t;

endpackage : ppl_pkg

// ==== hdl/ppl_loader.sv ====
// ppl_loader: fetches one preload word per port and scatters its bits into
// three configuration writes for that port
// assumes a word source answering rd_req with a one-cycle rd_ack and a
// configuration space that applies cfg_data under cfg_mask on cfg_wr
`timescale 1ns/1ps
module ppl_loader #(
  parameter int NPORTS = ppl_pkg::NUM_PORTS
) (
  input  wire logic        mclk,        // 250 MHz clock
  input  wire logic        rst_n,       // async reset, active low
  input  wire logic        ce,          // clock enable, freezes state when low
  input  wire logic        start,       // begin a preload pass
  output logic             rd_req_q,    // word read request, held until ack
  output logic [7:0]       rd_addr_q,   // word address of the request
  input  wire logic        rd_ack,      // word returned this cycle
  input  wire logic [15:0] rd_data,     // returned preload word
  output logic             cfg_wr_q,    // configuration write strobe
  output logic [2:0]       cfg_port_q,  // target port of the write
  output logic [11:0]      cfg_off_q,   // configuration byte offset
  output logic [31:0]      cfg_data_q,  // write data
  output logic [31:0]      cfg_mask_q,  // bits of cfg_data to apply
  output logic             busy_q,      // pass in progress
  output logic             done_q       // pass finished, one cycle
);

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // word address of a port
  function automatic logic [7:0] port_addr(input logic [2:0] p);
    port_addr = ppl_pkg::PRELOAD_BASE + ppl_pkg::PRELOAD_STEP * {5'h00, p};
  endfunction

  // power-management control image from a preload word
  function automatic logic [31:0] pm_image(input logic [15:0] w);
    logic [31:0] img;
    img = 32'h0000_0000;
    img[ppl_pkg::RXPOL_DST] = w[ppl_pkg::RXPOL_SRC];
    img[ppl_pkg::PMGRP_DST +: ppl_pkg::PMGRP_W] = w[ppl_pkg::PMGRP_SRC +: ppl_pkg::PMGRP_W];
    pm_image = img;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  ppl_pkg::ppl_state_t state_q, state_d;
  logic [2:0]  port_q, port_d;
  logic [15:0] word_q, word_d;
  logic        rd_req_d, cfg_wr_d, busy_d, done_d;
  logic [7:0]  rd_addr_d;
  logic [2:0]  cfg_port_d;
  logic [11:0] cfg_off_d;
  logic [31:0] cfg_data_d, cfg_mask_d;
  logic        last_port;

  assign last_port = (port_q == 3'(NPORTS - 1));

  // next-state and output computation
  always_comb begin
    state_d    = state_q;
    port_d     = port_q;
    word_d     = word_q;
    rd_req_d   = rd_req_q;
    rd_addr_d  = rd_addr_q;
    cfg_wr_d   = 1'b0;
    cfg_port_d = cfg_port_q;
    cfg_off_d  = cfg_off_q;
    cfg_data_d = cfg_data_q;
    cfg_mask_d = cfg_mask_q;
    busy_d     = busy_q;
    done_d     = 1'b0;
    case (state_q)
      ppl_pkg::PPL_IDLE: begin
        if (start) begin
          port_d    = 3'h0;
          rd_req_d  = 1'b1;
          rd_addr_d = port_addr(3'h0);
          busy_d    = 1'b1;
          state_d   = ppl_pkg::PPL_FETCH;
        end
      end
      ppl_pkg::PPL_FETCH: begin
        if (rd_ack) begin
          word_d     = rd_data;
          rd_req_d   = 1'b0;
          cfg_wr_d   = 1'b1;
          cfg_port_d = port_q;
          cfg_off_d  = ppl_pkg::OFF_PM_CTRL;
          cfg_data_d = pm_image(rd_data);
          cfg_mask_d = ppl_pkg::MASK_PM_CTRL;
          state_d    = ppl_pkg::PPL_WR_VGA;
        end
      end
      ppl_pkg::PPL_WR_VGA: begin
        cfg_wr_d   = 1'b1;
        cfg_off_d  = ppl_pkg::OFF_VGA_CTRL;
        cfg_data_d = 32'h0000_0000;
        cfg_data_d[ppl_pkg::VGA_DST] = word_q[ppl_pkg::VGA_SRC];
        cfg_mask_d = ppl_pkg::MASK_VGA_CTRL;
        state_d    = ppl_pkg::PPL_WR_VEND;
      end
      ppl_pkg::PPL_WR_VEND: begin
        cfg_wr_d   = 1'b1;
        cfg_off_d  = ppl_pkg::OFF_VEND_CTRL5;
        cfg_data_d = 32'h0000_0000;
        cfg_data_d[ppl_pkg::VEND_DST +: 8] = word_q[ppl_pkg::VEND_SRC +: 8];
        cfg_mask_d = ppl_pkg::MASK_VEND_CTRL;
        if (last_port) begin
          busy_d  = 1'b0;
          done_d  = 1'b1;
          state_d = ppl_pkg::PPL_IDLE;
        end else begin
          port_d    = port_q + 3'h1;
          rd_req_d  = 1'b1;
          rd_addr_d = port_addr(port_q + 3'h1);
          state_d   = ppl_pkg::PPL_FETCH;
        end
      end
      default: state_d = ppl_pkg::PPL_IDLE;
    endcase
  end

  // state registers, frozen while ce is low
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q    <= ppl_pkg::PPL_IDLE;
      port_q     <= 3'h0;
      word_q     <= 16'h0000;
      rd_req_q   <= 1'b0;
      rd_addr_q  <= 8'h00;
      cfg_wr_q   <= 1'b0;
      cfg_port_q <= 3'h0;
      cfg_off_q  <= 12'h000;
      cfg_data_q <= 32'h0000_0000;
      cfg_mask_q <= 32'h0000_0000;
      busy_q     <= 1'b0;
      done_q     <= 1'b0;
    end else if (ce) begin
      state_q    <= state_d;
      port_q     <= port_d;
      word_q     <= word_d;
      rd_req_q   <= rd_req_d;
      rd_addr_q  <= rd_addr_d;
      cfg_wr_q   <= cfg_wr_d;
      cfg_port_q <= cfg_port_d;
      cfg_off_q  <= cfg_off_d;
      cfg_data_q <= cfg_data_d;
      cfg_mask_q <= cfg_mask_d;
      busy_q     <= busy_d;
      done_q     <= done_d;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  fetch_addr_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rd_req_q |-> (rd_addr_q == port_addr(port_q)) && (rd_addr_q <= ppl_pkg::PRELOAD_LAST))
    else $error("preload fetch address does not match port");

  pm_rxpol_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg_wr_q && cfg_off_q == ppl_pkg::OFF_PM_CTRL)
      |-> cfg_data_q[14] == word_q[6] && cfg_mask_q[14])
    else $error("rx polarity bit misplaced");

  pm_l0s_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg_wr_q && cfg_off_q == ppl_pkg::OFF_PM_CTRL) |-> cfg_data_q[13:12] == word_q[5:4])
    else $error("l0s enable field misplaced");

  pm_l1_delay_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg_wr_q && cfg_off_q == ppl_pkg::OFF_PM_CTRL) |-> cfg_data_q[11:10] == word_q[3:2])
    else $error("l1 delay select misplaced");

  pm_d3_l1_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg_wr_q && cfg_off_q == ppl_pkg::OFF_PM_CTRL) |-> cfg_data_q[9:8] == word_q[1:0])
    else $error("d3 enters l1 field misplaced");

  pm_group_mask_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && rd_ack && rd_req_q) |=> cfg_wr_q && cfg_mask_q == 32'h0000_7F00
      && cfg_data_q[13:8] == $past(rd_data[5:0]))
    else $error("pm group not written after fetch");

  vga_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && cfg_wr_q && cfg_off_q == ppl_pkg::OFF_PM_CTRL) |=> cfg_wr_q
      && cfg_off_q == ppl_pkg::OFF_VGA_CTRL && cfg_data_q[31] == word_q[7])
    else $error("vga decode write missing or wrong");

  vend_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (ce && cfg_wr_q && cfg_off_q == ppl_pkg::OFF_VGA_CTRL) |=> cfg_wr_q
      && cfg_off_q == ppl_pkg::OFF_VEND_CTRL5 && cfg_data_q[31:24] == word_q[15:8])
    else $error("vendor control byte write missing or wrong");

  // pass end, follow-on fetch and idle quiet: the far side relies on these levels
  done_last_a: assert property (@(posedge mclk) disable iff (!rst_n)
    done_q |-> cfg_wr_q && !busy_q && cfg_off_q == ppl_pkg::OFF_VEND_CTRL5
      && cfg_port_q == 3'(NPORTS - 1))
    else $error("pass ended away from the last port");

  next_fetch_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (cfg_wr_q && cfg_off_q == ppl_pkg::OFF_VEND_CTRL5 && !done_q)
      |-> rd_req_q && busy_q && rd_addr_q == port_addr(cfg_port_q + 3'h1))
    else $error("next port fetch missing after vendor write");

  idle_no_fetch_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !busy_q |-> !rd_req_q)
    else $error("fetch request outside a pass");

endmodule // ppl_loader

// ==== bench/ppl_eeprom_model.sv ====
// ppl_eeprom_model: word source in place of the serial preload memory
// assumes requests held until answered; answers change on the falling edge
`timescale 1ns/1ps
module ppl_eeprom_model (
  input  wire logic        mclk,    // loader clock
  input  wire logic        rd_req,  // word request level
  input  wire logic [7:0]  rd_addr, // word address
  input  wire logic [15:0] salt,    // pattern mixed into each word
  input  wire logic [3:0]  dly,     // wait cycles before answering
  output logic             rd_ack,  // answer strobe
  output logic [15:0]      rd_data  // word, scrambled outside answers
);
  logic [3:0] wait_cnt;
  // ------------------------------------------------------------
  // answer timing
  // ------------------------------------------------------------
  initial begin
    rd_ack = 1'b0;
    rd_data = 16'h0000;
    wait_cnt = 4'h0;
  end
  // wait dly cycles, then answer; between answers the last word alternates with its inverse
  always @(negedge mclk) begin
    if (rd_req && wait_cnt >= dly) begin
      rd_ack  <= 1'b1;
      rd_data <= salt ^ {rd_addr, ~rd_addr};
    end else begin
      rd_ack   <= 1'b0;
      rd_data  <= ~rd_data;
      wait_cnt <= rd_req ? wait_cnt + 4'h1 : 4'h0;
    end
  end
endmodule // ppl_eeprom_model

// ==== bench/tb_ppl_loader.sv ====
// tb_ppl_loader: preload passes against the word source model
// assumes ppl_pkg and ppl_loader compiled first
`timescale 1ns/1ps
module tb_ppl_loader;
  logic        mclk, rst_n, ce, start, rd_req_q, rd_ack, cfg_wr_q, busy_q, done_q;
  logic [7:0]  rd_addr_q;
  logic [15:0] rd_data, salt;
  logic [3:0]  dly;
  logic [2:0]  cfg_port_q;
  logic [11:0] cfg_off_q;
  logic [31:0] cfg_data_q, cfg_mask_q;
  int          n_errors, cmp_count, n_wr, n_rd;
  ppl_loader i_ppl_loader (.mclk(mclk), .rst_n(rst_n), .ce(ce), .start(start),
    .rd_req_q(rd_req_q), .rd_addr_q(rd_addr_q), .rd_ack(rd_ack), .rd_data(rd_data),
    .cfg_wr_q(cfg_wr_q), .cfg_port_q(cfg_port_q), .cfg_off_q(cfg_off_q),
    .cfg_data_q(cfg_data_q), .cfg_mask_q(cfg_mask_q), .busy_q(busy_q), .done_q(done_q));
  ppl_eeprom_model i_ppl_eeprom_model (.mclk(mclk), .rd_req(rd_req_q), .rd_addr(rd_addr_q),
    .salt(salt), .dly(dly), .rd_ack(rd_ack), .rd_data(rd_data));
  // ------------------------------------------------------------
  // clock and helpers
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // check write i against the word of port i/3; order 74h, 70h, 88h
  task automatic wr_check(input int i);
    logic [7:0]  a;
    logic [15:0] w;
    a = 8'h80 + 8'(2 * (i / 3));
    w = salt ^ {a, ~a};
    check("cfg_port", {29'h0, cfg_port_q}, 32'(i / 3));
    check("busy_done", {30'h0, busy_q, done_q}, (i == 17) ? 32'h1 : 32'h2);
    case (i % 3)
      0: begin
        check("off74", {20'h0, cfg_off_q}, 32'h074);
        check("data74", cfg_data_q, {17'h0, w[6], w[5:4], w[3:2], w[1:0], 8'h00});
        check("mask74", cfg_mask_q, 32'h0000_7F00);
      end
      1: begin
        check("off70", {20'h0, cfg_off_q}, 32'h070);
        check("data70", cfg_data_q, {w[7], 31'h0});
        check("mask70", cfg_mask_q, 32'h8000_0000);
      end
      default: begin
        check("off88", {20'h0, cfg_off_q}, 32'h088);
        check("data88", cfg_data_q, {w[15:8], 24'h0});
        check("mask88", cfg_mask_q, 32'hFF00_0000);
      end
    endcase
  endtask
  // watch taken requests and applied writes
  always @(posedge mclk) begin
    if (rst_n && ce && rd_req_q && rd_ack) begin
      check("rd_addr", {24'h0, rd_addr_q}, {24'h0, 8'h80 + 8'(2 * n_rd)});
      n_rd++;
    end
    if (rst_n && ce && cfg_wr_q === 1'b1) begin
      wr_check(n_wr);
      n_wr++;
    end
  end
  task automatic do_reset();
    rst_n = 1'b0;
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    check("idle", {busy_q, done_q, rd_req_q, cfg_wr_q}, 32'h0);
  endtask
  // one pass; gap pulses ce low, start stays up for the first seven cycles and is ignored once busy
  task automatic run_pass(input int t, input logic [15:0] s, input logic [3:0] d, input bit gap);
    int k;
    salt = s;
    dly = d;
    n_wr = 0;
    n_rd = 0;
    start = 1'b1;
    k = 0;
    while (!(done_q === 1'b1 && ce === 1'b1) && k < 400) begin
      @(negedge mclk);
      if (k == 6) start = 1'b0;
      ce = gap ? (k % 3 != 0) : 1'b1;
      k++;
    end
    ce = 1'b1;
    @(negedge mclk);
    check("busy_end", {busy_q, done_q}, 32'h0);
    check("reads", 32'(n_rd), 32'd6);
    check("writes", 32'(n_wr), 32'd18);
    $display("test %0d done", t);
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    {rst_n, ce, start, salt, dly} = {1'b0, 1'b1, 1'b0, 16'h0000, 4'h0};
    {n_errors, cmp_count, n_wr, n_rd} = {32'd0, 32'd0, 32'd0, 32'd0};
    do_reset();
    run_pass(1, 16'h0000, 4'h0, 1'b0);
    run_pass(2, 16'hFFFF, 4'h5, 1'b1);
    run_pass(3, 16'hA5C3, 4'h2, 1'b0);
    // mid-pass reset: fresh counters so the partial pass checks from port 0
    n_wr = 0;
    n_rd = 0;
    start = 1'b1;
    repeat (10) @(negedge mclk);
    start = 1'b0;
    do_reset();
    repeat (2) @(negedge mclk);
    check("post_reset", {29'h0, busy_q, rd_req_q, cfg_wr_q}, 32'h0);
    $display("test 4 done");
    run_pass(5, 16'h3C96, 4'h1, 1'b0);
    final_report();
  end
  // watchdog well past the longest expected run
  initial begin
    #20000;
    n_errors++;
    $display("watchdog expired");
    final_report();
  end
endmodule // tb_ppl_loader
